/* File: testbench/uresp_tb.sv */
// Self-checking bench for the receive error and serial status block.
// Assumes the transmitter model and a one-clock register master.
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; $display("wrong value at %0t: got %h want %h", $time, (g), (e)); end end

module uresp_tb;
    import uresp_pkg::*;
    logic        REF_CLK, RESET_N, BUS_WR, BUS_RD, IRQ;
    logic        pend = 1'b0;            // Read taken last edge
    logic [7:0]  BUS_ADDR, rx_data;
    logic [15:0] BUS_WDATA, BUS_RDATA, e;
    logic [3:0]  evt;                    // Stop, tx empty, break, idle
    logic        rx_done, rx_perr, rx_ferr;
    logic        tx_end = 1'b1;          // Transmitter end level
    logic [7:0]  rb [64];                // Random fill bytes
    logic [15:0] exp_q [$];              // Expected read data
    int          fail_count = 0, total_checks = 0, seed = 27264;

    uresp_top u_dut (.REF_CLK(REF_CLK), .RESET_N(RESET_N), .BUS_ADDR(BUS_ADDR),
        .BUS_WDATA(BUS_WDATA), .BUS_WR(BUS_WR), .BUS_RD(BUS_RD), .BUS_RDATA(BUS_RDATA),
        .RX_CHAR_DONE(rx_done), .RX_CHAR_DATA(rx_data), .RX_CHAR_PERR(rx_perr),
        .RX_CHAR_FERR(rx_ferr), .TX_STOP_EVT(evt[0]), .TX_FIFO_EMPTY_EVT(evt[1]),
        .BREAK_EVT(evt[2]), .RX_IDLE_EVT(evt[3]), .TX_END(tx_end), .IRQ(IRQ));
    uresp_tx_model u_tx (.clk(REF_CLK), .done(rx_done), .data(rx_data), .perr(rx_perr),
        .ferr(rx_ferr));

    initial begin
        REF_CLK = 1'b0;
        forever #5 REF_CLK = ~REF_CLK;
    end

    // ------------------------------------------------------------
    // Bus tasks and read scoreboard
    // ------------------------------------------------------------
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge REF_CLK);
        BUS_ADDR  <= a;
        BUS_WDATA <= d;
        BUS_WR    <= 1'b1;
        @(posedge REF_CLK);
        BUS_WR    <= 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [15:0] x);
        @(posedge REF_CLK);
        BUS_ADDR <= a;
        BUS_RD   <= 1'b1;
        exp_q.push_back(x);
        @(posedge REF_CLK);
        BUS_RD   <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    always @(posedge REF_CLK) begin
        if (pend) begin
            e = exp_q.pop_front();
            `CHK(BUS_RDATA, e)
        end
        pend <= BUS_RD;
    end

    task note(input string s);
        $display("test %s done", s);
    endtask

    task complete_run;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Hang guard, far beyond the few hundred cycles the run needs
    initial begin
        repeat (5000) @(posedge REF_CLK);
        fail_count++;
        complete_run;
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {RESET_N, BUS_WR, BUS_RD, BUS_ADDR, BUS_WDATA, evt} = '0;
        repeat (20) @(posedge REF_CLK);
        RESET_N <= 1'b1;
        rd(OFS_SERIAL_STATUS, 16'h0060);
        rd(OFS_RX_ERROR_CNT, 16'h0000);
        rd(8'h1c, 16'h0000);
        note("reset");
        wr(OFS_SERIAL_CTRL, 16'h0010);
        for (int i = 0; i < 6; i++) u_tx.send({8'h40 + 8'(i), i < 3, i >= 2});
        rd(OFS_RX_ERROR_CNT, 16'h0304);
        wr(OFS_RX_ERROR_CNT, 16'hffff);
        rd(OFS_RX_ERROR_CNT, 16'h0304);
        wr(OFS_SERIAL_STATUS, 16'hffff);
        wr(OFS_SERIAL_STATUS, 16'h0000);
        rd(OFS_SERIAL_STATUS, 16'h00e6);
        wr(OFS_SERIAL_STATUS, 16'h0000);
        rd(OFS_SERIAL_STATUS, 16'h0044);
        note("counts and flags");
        rd(OFS_RX_FIFO_DATA, 16'h0040);
        rd(OFS_RX_FIFO_DATA, 16'h0041);
        rd(OFS_RX_ERROR_CNT, 16'h0104);
        for (int i = 2; i < 7; i++) rd(OFS_RX_FIFO_DATA, i < 6 ? 16'h0040 + 16'(i) : 16'h0);
        rd(OFS_RX_ERROR_CNT, 16'h0000);
        note("pops");
        for (int i = 0; i < 64; i++) begin
            rb[i] = 8'($random(seed));
            u_tx.send({rb[i], 2'b01});
        end
        rd(OFS_RX_ERROR_CNT, 16'h0000);
        u_tx.send(10'h3fe);
        rd(OFS_RX_ERROR_CNT, 16'h0000);
        rd(OFS_SERIAL_STATUS, 16'h02ca);
        wr(OFS_SERIAL_CTRL, 16'h0000);
        rd(OFS_SERIAL_STATUS, 16'h02ca);
        wr(OFS_SERIAL_CTRL, 16'h0010);
        rd(OFS_RX_FIFO_DATA, {8'h00, rb[0]});
        rd(OFS_RX_ERROR_CNT, 16'h003f);
        u_tx.send(10'h3fe);
        rd(OFS_RX_ERROR_CNT, 16'h003f);
        wr(OFS_SERIAL_STATUS, 16'h0000);
        u_tx.send(10'h3fe);
        rd(OFS_RX_ERROR_CNT, 16'h013f);
        wr(OFS_SERIAL_CTRL, 16'h0011);
        u_tx.send(10'h3fe);
        rd(OFS_SERIAL_STATUS, 16'h00ca);
        note("overrun");
        wr(OFS_INT_MASK, 16'h0008);
        `CHK(IRQ, 1'b0)
        @(posedge REF_CLK);
        evt <= 4'hf;
        tx_end <= 1'b0;
        @(posedge REF_CLK);
        evt <= 4'h0;
        repeat (3) @(posedge REF_CLK);
        `CHK(IRQ, 1'b1)
        rd(OFS_INT_STATUS, 16'h000f);
        rd(OFS_SERIAL_STATUS, 16'h01bb);
        wr(OFS_INT_STATUS, 16'h000f);
        rd(OFS_INT_STATUS, 16'h0000);
        `CHK(IRQ, 1'b0)
        note("interrupt");
        wr(OFS_SERIAL_CTRL, 16'h0010);
        u_tx.send(10'h3fe);
        rd(OFS_SERIAL_STATUS, 16'h03bb);
        RESET_N <= 1'b0;
        tx_end  <= 1'b1;
        repeat (2) @(posedge REF_CLK);
        RESET_N <= 1'b1;
        rd(OFS_SERIAL_STATUS, 16'h0060);
        rd(OFS_RX_ERROR_CNT, 16'h0000);
        note("reset again");
        repeat (2) @(posedge REF_CLK);
        complete_run;
    end
endmodule // uresp_tb

/* File: testbench/uresp_tx_model.sv */
// Remote serial transmitter model: hands finished characters to the block.
// Assumes the bench calls send right after a rising clock edge.
`timescale 1ns/1ps

module uresp_tx_model (
    input  wire logic       clk,
    output logic            done,
    output logic [7:0]      data,
    output logic            perr,
    output logic            ferr
);
    logic       go = 1'b0;    // Character waiting to go out
    logic [9:0] nxt;          // Data, parity error, framing error

    initial {done, data, perr, ferr} = 11'h2a5;

    // ------------------------------------------------------------
    // Strobe driver
    // ------------------------------------------------------------
    // Idle lines invert every cycle, so a stale value never passes for fresh
    always @(posedge clk) begin
        if (go) begin
            {data, perr, ferr} <= nxt;
            done               <= 1'b1;
            go                 <= 1'b0;
        end else begin
            {data, perr, ferr} <= ~{data, perr, ferr};
            done               <= 1'b0;
        end
    end

    // One strobe per call, two cycles apart
    task send(input logic [9:0] c);
        nxt = c;
        go <= 1'b1;
        repeat (2) @(posedge clk);
    endtask
endmodule // uresp_tx_model

/* File: verilog/uresp_pkg.sv */
// Constants for the receive error accounting and serial status block.
// Assumes a 16-bit register port with byte addresses of aligned words.

package uresp_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W     = 8;   // Register address width
    localparam int unsigned DATA_W     = 16;  // Register data width
    localparam int unsigned CHAR_W     = 8;   // Received character width
    localparam int unsigned FIFO_DEPTH = 64;  // Receive FIFO entries
    localparam int unsigned PTR_W      = 6;   // FIFO pointer width
    localparam int unsigned LVL_W      = 7;   // FIFO level width (0..64)
    localparam int unsigned CNT_W      = 6;   // Error count width, wraps mod 64

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_RX_FIFO_DATA  = 8'h00; // Pops one character
    localparam logic [7:0] OFS_RX_ERROR_CNT  = 8'h04; // Read only
    localparam logic [7:0] OFS_SERIAL_STATUS = 8'h08; // Read, then write 0
    localparam logic [7:0] OFS_SERIAL_CTRL   = 8'h0c; // Receiver enable, mode
    localparam logic [7:0] OFS_INT_STATUS    = 8'h10; // Write 1 to clear
    localparam logic [7:0] OFS_INT_MASK      = 8'h14; // 1 lets a bit through

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned ERRCNT_PER_LSB = 8;  // Parity count at 13:8
    localparam int unsigned ERRCNT_FER_LSB = 0;  // Framing count at 5:0
    localparam int unsigned ST_OVERRUN_FLAG = 9;   // overrun_flag
    localparam int unsigned ST_TSF  = 8;   // tx_stop_flag
    localparam int unsigned ST_ER   = 7;   // rx_error_flag
    localparam int unsigned ST_TX_END_FLAG = 6;   // tx_end_flag
    localparam int unsigned ST_TX_FIFO_EMPTY_FLAG = 5;   // tx_fifo_empty_flag
    localparam int unsigned ST_BRK  = 4;   // break_flag
    localparam int unsigned ST_FER  = 3;   // Head character framing error
    localparam int unsigned ST_PER  = 2;   // Head character parity error
    localparam int unsigned ST_RDF  = 1;   // rx_fifo_full_flag
    localparam int unsigned ST_DR   = 0;   // rx_data_ready_flag
    localparam int unsigned CTL_RE   = 4;  // receiver_enable
    localparam int unsigned CTL_SYNC = 0;  // 1 selects synchronous mode
    localparam int unsigned INT_PUSH = 0;  // Character stored
    localparam int unsigned INT_ERR  = 1;  // Errored character stored
    localparam int unsigned INT_OVR  = 2;  // Overrun
    localparam int unsigned INT_BRK  = 3;  // Break seen
    localparam int unsigned INT_W    = 4;  // Interrupt status width

    // Clearable status bits: OVERRUN_FLAG TX_STOP_FLAG ER TX_FIFO_EMPTY_FLAG BREAK_FLAG RX_FIFO_FULL_FLAG DR
    localparam logic [15:0] ST_CLEAR_MASK = 16'h03b3;

    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam logic [15:0] ST_FLAG_RESET = 16'h0020; // TX_FIFO_EMPTY_FLAG starts set
    localparam logic [15:0] CTL_RESET     = 16'h0000;
    localparam logic        TX_END_FLAG_RESET    = 1'b1;     // Transmitter starts idle
    localparam logic [LVL_W-1:0] RDF_LEVEL_DEFAULT = 7'h01; // Fill trigger

endpackage

/* File: verilog/uresp_top.sv */
// Receive FIFO with error accounting, serial status flags and interrupt.
// Assumes a same-clock receiver that pulses once per finished character
// and a master on the plain register port that never overlaps strobes.
//
// Behaviour
// - Error count register is read only
// - Bits 13:8 count parity-errored FIFO bytes
// - Bits 5:0 count framing-errored FIFO bytes
// - Counts rise on errored store, fall when it is read
// - Sixty-four errored bytes read as zero
// - Reserved bits always read zero
// - Writing one never sets a status flag
// - Write zero clears only after reading one
// - End, framing, parity status bits read only
// - Overrun set when full FIFO gets character
// - Overrun meaningful only in asynchronous mode
// - Reset clears overrun and status flags, but sets tx FIFO empty and tx end
// - Receiver disable leaves overrun flag alone
// - Overrun keeps FIFO, drops new character
// - Overrun blocks reception until cleared

`timescale 1ns/1ps

module uresp_top #(
    parameter logic [uresp_pkg::LVL_W-1:0] RDF_LEVEL = uresp_pkg::RDF_LEVEL_DEFAULT
) (
    input  wire logic                           REF_CLK,
    input  wire logic                           RESET_N,
    input  wire logic [uresp_pkg::ADDR_W-1:0]   BUS_ADDR,
    input  wire logic [uresp_pkg::DATA_W-1:0]   BUS_WDATA,
    input  wire logic                           BUS_WR,
    input  wire logic                           BUS_RD,
    output logic      [uresp_pkg::DATA_W-1:0]   BUS_RDATA,
    input  wire logic                           RX_CHAR_DONE,
    input  wire logic [uresp_pkg::CHAR_W-1:0]   RX_CHAR_DATA,
    input  wire logic                           RX_CHAR_PERR,
    input  wire logic                           RX_CHAR_FERR,
    input  wire logic                           TX_STOP_EVT,
    input  wire logic                           TX_FIFO_EMPTY_EVT,
    input  wire logic                           BREAK_EVT,
    input  wire logic                           RX_IDLE_EVT,
    input  wire logic                           TX_END,
    output logic                                IRQ
);
    import uresp_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [CHAR_W+1:0]  fifo_mem [FIFO_DEPTH];  // {perr, ferr, data}
    logic [PTR_W-1:0]   wr_ptr_q;               // Next slot to fill
    logic [PTR_W-1:0]   rd_ptr_q;               // Head slot
    logic [LVL_W-1:0]   level_q;                // Characters held
    logic [CNT_W-1:0]   per_cnt_q;              // Parity-errored bytes
    logic [CNT_W-1:0]   fer_cnt_q;              // Framing-errored bytes
    logic [15:0]        flag_q;                 // Clearable status flags
    logic [15:0]        flag_d;
    logic [15:0]        armed_q;                // Flags software saw as 1
    logic [15:0]        ctrl_q;                 // Control register
    logic               tx_end_flag_q;                 // Sampled transmit end
    logic [INT_W-1:0]   int_st_q;               // Sticky interrupt events
    logic [INT_W-1:0]   int_st_d;
    logic [INT_W-1:0]   int_mask_q;             // Interrupt enables
    logic [DATA_W-1:0]  rdata_q;                // Read data, one cycle late
    logic               irq_q;                  // Interrupt output flop

    logic               async_mode;             // Low control bit selects async
    logic               rx_enabled;             // Receiver enable bit
    logic               fifo_full;              // All 64 slots taken
    logic               fifo_empty;             // Nothing to read
    logic               accept;                 // Character taken by block
    logic               push;                   // Character stored
    logic               ovr_event;              // Character lost to overrun
    logic               pop;                    // Software takes head
    logic               in_perr;                // Parity error kept for async
    logic               in_ferr;                // Framing error kept for async
    logic               head_perr;              // Head entry parity error
    logic               head_ferr;              // Head entry framing error
    logic [CHAR_W+1:0]  head_word;              // Head entry
    logic [15:0]        set_vec;                // Hardware flag sets
    logic [15:0]        clr_vec;                // Software flag clears
    logic               wr_status;              // Write to status register
    logic               rd_status;              // Read of status register
    logic [15:0]        status_view;            // Status as software sees it
    logic [DATA_W-1:0]  rdata_d;                // Read mux result

    // ------------------------------------------------------------
    // Receive path decisions
    // ------------------------------------------------------------
    // Decode the control bits and decide what a finished character does
    always_comb begin
        async_mode = ~ctrl_q[CTL_SYNC];
        rx_enabled = ctrl_q[CTL_RE];
        fifo_full  = (level_q == LVL_W'(FIFO_DEPTH));
        fifo_empty = (level_q == '0);
        // A pending overrun stalls the receiver entirely
        accept     = RX_CHAR_DONE & rx_enabled & ~flag_q[ST_OVERRUN_FLAG];
        // Full FIFO keeps old bytes and loses the new one
        push       = accept & ~fifo_full;
        // Only async mode reports the loss; sync mode drops silently
        ovr_event  = accept & fifo_full & async_mode;
        // Error bits only mean anything in async mode
        in_perr    = RX_CHAR_PERR & async_mode;
        in_ferr    = RX_CHAR_FERR & async_mode;
        head_word  = fifo_mem[rd_ptr_q];
        head_perr  = ~fifo_empty & head_word[CHAR_W+1];
        head_ferr  = ~fifo_empty & head_word[CHAR_W];
        pop        = BUS_RD & (BUS_ADDR == OFS_RX_FIFO_DATA) & ~fifo_empty;
        wr_status  = BUS_WR & (BUS_ADDR == OFS_SERIAL_STATUS);
        rd_status  = BUS_RD & (BUS_ADDR == OFS_SERIAL_STATUS);
    end

    // ------------------------------------------------------------
    // Receive FIFO storage
    // ------------------------------------------------------------
    // Data array has no reset; only the pointers and level carry state
    always_ff @(posedge REF_CLK) begin
        if (push) begin
            fifo_mem[wr_ptr_q] <= {in_perr, in_ferr, RX_CHAR_DATA};
        end
    end

    // Pointers and level; pointers wrap naturally at 64
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            level_q  <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + PTR_W'(1);
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + PTR_W'(1);
            end
            if (push && !pop) begin
                level_q <= level_q + LVL_W'(1);
            end else if (pop && !push) begin
                level_q <= level_q - LVL_W'(1);
            end
        end
    end

    // ------------------------------------------------------------
    // Error counts
    // ------------------------------------------------------------
    // Counts follow the FIFO contents: up on store, down on read.
    // Six bits wrap, so a FIFO of 64 errored bytes reads as zero.
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            per_cnt_q <= '0;
            fer_cnt_q <= '0;
        end else begin
            // Each errored store also raises the receive error flag
            per_cnt_q <= per_cnt_q + CNT_W'(push & in_perr)
                                   - CNT_W'(pop & head_perr);
            fer_cnt_q <= fer_cnt_q + CNT_W'(push & in_ferr)
                                   - CNT_W'(pop & head_ferr);
        end
    end

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    // Hardware sets, software clears with a read of 1 then a write of 0
    always_comb begin
        set_vec          = '0;
        set_vec[ST_OVERRUN_FLAG] = ovr_event;
        set_vec[ST_TSF]  = TX_STOP_EVT;
        set_vec[ST_ER]   = push & (in_perr | in_ferr);
        set_vec[ST_TX_FIFO_EMPTY_FLAG] = TX_FIFO_EMPTY_EVT;
        set_vec[ST_BRK]  = BREAK_EVT;
        set_vec[ST_RDF]  = push & ((level_q + LVL_W'(1)) >= RDF_LEVEL);
        set_vec[ST_DR]   = RX_IDLE_EVT;
        // Write data of 1 clears nothing; 0 clears only armed bits
        clr_vec = wr_status ? (armed_q & ~BUS_WDATA & ST_CLEAR_MASK) : '0;
        // Set beats clear; software can never set a flag
        flag_d  = ((flag_q & ~clr_vec) | set_vec) & ST_CLEAR_MASK;
    end

    // Flag register; receiver disable does not touch it
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            flag_q <= ST_FLAG_RESET;
        end else begin
            flag_q <= flag_d;
        end
    end

    // Remember which flags a status read returned as 1.
    // A write consumes the arming so a stale read cannot clear later.
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            armed_q <= '0;
        end else if (rd_status) begin
            armed_q <= flag_q & ST_CLEAR_MASK;
        end else if (wr_status) begin
            armed_q <= '0;
        end
    end

    // Transmit end is a level from the transmitter, registered
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            tx_end_flag_q <= TX_END_FLAG_RESET;
        end else begin
            tx_end_flag_q <= TX_END;
        end
    end

    // Read-only bits come from state, never from write data
    always_comb begin
        status_view          = flag_q & ST_CLEAR_MASK;
        status_view[ST_TX_END_FLAG] = tx_end_flag_q;
        status_view[ST_FER]  = head_ferr;
        status_view[ST_PER]  = head_perr;
    end

    // ------------------------------------------------------------
    // Control and interrupt registers
    // ------------------------------------------------------------
    // Control: only the enable and mode bits are stored
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            ctrl_q <= CTL_RESET;
        end else if (BUS_WR && (BUS_ADDR == OFS_SERIAL_CTRL)) begin
            ctrl_q           <= '0;
            ctrl_q[CTL_RE]   <= BUS_WDATA[CTL_RE];
            ctrl_q[CTL_SYNC] <= BUS_WDATA[CTL_SYNC];
        end
    end

    // Sticky events, write 1 to clear, a new event wins
    always_comb begin
        int_st_d = int_st_q;
        if (BUS_WR && (BUS_ADDR == OFS_INT_STATUS)) begin
            int_st_d = int_st_q & ~BUS_WDATA[INT_W-1:0];
        end
        int_st_d[INT_PUSH] = int_st_d[INT_PUSH] | push;
        int_st_d[INT_ERR]  = int_st_d[INT_ERR] | set_vec[ST_ER];
        int_st_d[INT_OVR]  = int_st_d[INT_OVR] | ovr_event;
        int_st_d[INT_BRK]  = int_st_d[INT_BRK] | BREAK_EVT;
    end

    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            int_st_q <= '0;
        end else begin
            int_st_q <= int_st_d;
        end
    end

    // Mask register
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            int_mask_q <= '0;
        end else if (BUS_WR && (BUS_ADDR == OFS_INT_MASK)) begin
            int_mask_q <= BUS_WDATA[INT_W-1:0];
        end
    end

    // Level interrupt; one flop after the sticky bit for a clean output
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(int_st_q & int_mask_q);
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Address decode; unmapped addresses read as zero
    always_comb begin
        rdata_d = '0;
        if (BUS_ADDR == OFS_RX_FIFO_DATA) begin
            rdata_d[CHAR_W-1:0] = fifo_empty ? '0 : head_word[CHAR_W-1:0];
        end else if (BUS_ADDR == OFS_RX_ERROR_CNT) begin
            // Reserved 15:14 and 7:6 stay zero
            rdata_d[ERRCNT_PER_LSB +: CNT_W] = per_cnt_q;
            rdata_d[ERRCNT_FER_LSB +: CNT_W] = fer_cnt_q;
        end else if (BUS_ADDR == OFS_SERIAL_STATUS) begin
            rdata_d = status_view;
        end else if (BUS_ADDR == OFS_SERIAL_CTRL) begin
            rdata_d = ctrl_q;
        end else if (BUS_ADDR == OFS_INT_STATUS) begin
            rdata_d[INT_W-1:0] = int_st_q;
        end else if (BUS_ADDR == OFS_INT_MASK) begin
            rdata_d[INT_W-1:0] = int_mask_q;
        end
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= BUS_RD ? rdata_d : '0;
        end
    end

    assign BUS_RDATA = rdata_q;
    assign IRQ       = irq_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_counts_idle;
        !push && !pop;
    endsequence

    sequence s_overrun_hit;
        accept && fifo_full && async_mode;
    endsequence

    // Write to the error count register leaves the counts alone
    property p_errcnt_ro;
        @(posedge REF_CLK) disable iff (!RESET_N)
        (BUS_WR && BUS_ADDR == OFS_RX_ERROR_CNT) and s_counts_idle
            |=> $stable(per_cnt_q) && $stable(fer_cnt_q);
    endproperty
    a_errcnt_ro: assert property (p_errcnt_ro)
        else $error("error count changed by a write");

    // Parity-errored store alone raises the parity count by one
    property p_per_up;
        @(posedge REF_CLK) disable iff (!RESET_N)
        push && in_perr && !pop |=> per_cnt_q == $past(per_cnt_q) + CNT_W'(1);
    endproperty
    a_per_up: assert property (p_per_up)
        else $error("parity count did not advance");

    // Framing-errored read alone lowers the framing count by one
    property p_fer_down;
        @(posedge REF_CLK) disable iff (!RESET_N)
        pop && head_ferr && !push |=> fer_cnt_q == $past(fer_cnt_q) - CNT_W'(1);
    endproperty
    a_fer_down: assert property (p_fer_down)
        else $error("framing count did not drop on read");

    // Reserved bits of both registers read zero
    property p_reserved_zero;
        @(posedge REF_CLK) disable iff (!RESET_N)
        BUS_RD && (BUS_ADDR == OFS_RX_ERROR_CNT || BUS_ADDR == OFS_SERIAL_STATUS)
            |=> ($past(BUS_ADDR) == OFS_SERIAL_STATUS) ? BUS_RDATA[15:10] == 6'h00
                : (BUS_RDATA[15:14] == 2'h0 && BUS_RDATA[7:6] == 2'h0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits read nonzero");

    // Without a hardware set no flag rises
    property p_no_sw_set;
        @(posedge REF_CLK) disable iff (!RESET_N)
        set_vec == '0 |=> (flag_q & ~$past(flag_q)) == 16'h0000;
    endproperty
    a_no_sw_set: assert property (p_no_sw_set)
        else $error("status flag set without event");

    // Unarmed write of zero clears nothing
    property p_need_read;
        @(posedge REF_CLK) disable iff (!RESET_N)
        wr_status && armed_q == '0 |=> ($past(flag_q) & ~flag_q) == 16'h0000;
    endproperty
    a_need_read: assert property (p_need_read)
        else $error("flag cleared without prior read");

    // Character into a full FIFO in async mode raises overrun
    property p_overrun_set;
        @(posedge REF_CLK) disable iff (!RESET_N)
        s_overrun_hit |=> flag_q[ST_OVERRUN_FLAG] && level_q == $past(level_q) - LVL_W'($past(pop))
            ##1 flag_q[ST_OVERRUN_FLAG] || wr_status;
    endproperty
    a_overrun_set: assert property (p_overrun_set)
        else $error("overrun not flagged");

    // Sync mode never reports overrun
    property p_sync_no_ovr;
        @(posedge REF_CLK) disable iff (!RESET_N)
        !async_mode && !flag_q[ST_OVERRUN_FLAG] |=> !flag_q[ST_OVERRUN_FLAG];
    endproperty
    a_sync_no_ovr: assert property (p_sync_no_ovr)
        else $error("overrun raised in sync mode");

    // Overrun held while receiver off and no status write
    property p_re_keeps_ovr;
        @(posedge REF_CLK) disable iff (!RESET_N)
        flag_q[ST_OVERRUN_FLAG] && !rx_enabled && !wr_status |=> flag_q[ST_OVERRUN_FLAG];
    endproperty
    a_re_keeps_ovr: assert property (p_re_keeps_ovr)
        else $error("overrun lost while receiver disabled");

    // Pending overrun stores no further character
    property p_ovr_blocks;
        @(posedge REF_CLK) disable iff (!RESET_N)
        flag_q[ST_OVERRUN_FLAG] && RX_CHAR_DONE && !pop |=> level_q == $past(level_q);
    endproperty
    a_ovr_blocks: assert property (p_ovr_blocks)
        else $error("character stored during overrun");

    // Reset returns flags to their initial pattern
    property p_reset_flags;
        @(posedge REF_CLK)
        !RESET_N |=> flag_q == ST_FLAG_RESET;
    endproperty
    a_reset_flags: assert property (p_reset_flags)
        else $error("flags wrong after reset");

endmodule // uresp_top
